// ===== src/idec_map.svh
// Notes on behaviour
// - byte ops: opcode bits 13..8, destination bit 7, file address bits 6..0.
// - destination 0 writes the work register, 1 writes the file register; OP_CLRW raises neither wr_work_o nor wr_file_o.
// - bit ops: opcode bits 13..10, bit number 9..7, file address 6..0.
// - literal ops: opcode bits 13..8, 8-bit immediate bits 7..0.
// - call_far 10 0, jump_absolute 10 1, 11-bit target bits 10..0.
// - load_page_latch 11 0001 1, 7-bit immediate for pc_high_latch.
// - load_bank_select opcode bits 13..5, 5-bit immediate for bank_select.
// - branch_relative 11 001, 9-bit offset, two cycles.
// - add_pointer_offset 11 0001 0, pointer bit 6, 6-bit immediate.
// - pointer increment: opcode 13..3, pointer bit 2, ptr_update_mode 1..0.
// - add/sub with and without carry decode and update carry, digit carry, zero.
// - shifts update carry and zero; rotates update only carry.
// - and, or, xor with file update only zero.
// - skip-on-zero forms touch no flag, two cycles when skipping.
// - bit clear, set, test-clear, test-set by bits 13..10; tests two cycles on skip.
// - add_literal updates C, DC, Z; and_literal Z; or_literal; one cycle.
// - ret_sub, ret_interrupt, call_by_w, branch_by_w take two cycles.
// - clear_watchdog and standby touch timeout/powerdown flags; zero word is no-op.
// - option load, port-direction load with 3-bit select, software reset.
// - indexed indirect prefix 11 1111: bit 7 picks load or store, bit 6 pointer.
// - program counter change or true test takes two cycles, second a no-op.
// - indirect_file access with pointer msb set adds one cycle.
// - one instruction cycle spans four clock cycles.
`ifndef IDEC_MAP_SVH
`define IDEC_MAP_SVH
// ****************************************
// field positions
// ****************************************
`define IDEC_OP6_HI      13
`define IDEC_OP6_LO      8
`define IDEC_DEST_BIT    7
`define IDEC_BITN_HI     9
`define IDEC_BITN_LO     7
`define IDEC_PTR_OFS_BIT 6
`define IDEC_PTR_INC_BIT 2
`define IDEC_INDF0_ADDR  7'h00
`define IDEC_INDF1_ADDR  7'h01
// ****************************************
// flag mask bit positions
// ****************************************
`define IDEC_FL_C        0
`define IDEC_FL_DC       1
`define IDEC_FL_Z        2
`define IDEC_FL_PD       3
`define IDEC_FL_TO       4
// ****************************************
// timing and register map
// ****************************************
`define IDEC_CLK_PER_ICYC 3'h4
`define IDEC_REG_CTRL    4'h0
`define IDEC_REG_WORD    4'h1
`define IDEC_REG_STAT    4'h2
`define IDEC_REG_LAST    4'h3
`define IDEC_CTRL_RST    1'h0
`define IDEC_WORD_RST    14'h0000
`endif

// ===== src/idec_pkg.sv
package idec_pkg;
    typedef enum logic [1:0] {IDEC_Q1 = 2'b00, IDEC_Q2 = 2'b01, IDEC_Q3 = 2'b11, IDEC_Q4 = 2'b10} idec_phase_t;
    typedef enum logic [5:0] {
        OP_NOP, OP_ADD_W_TO_FILE, OP_ADD_W_FILE_CARRY, OP_AND_W_FILE, OP_ASR, OP_LSL, OP_LSR, OP_CLRF, OP_CLRW,
        OP_COMF, OP_DECF, OP_INCF, OP_OR_W_FILE, OP_MOVF, OP_MOVWF, OP_RLC, OP_RRC, OP_SUB_W_FROM_FILE,
        OP_SUB_W_FILE_BORROW, OP_SWAPF, OP_XOR_W_FILE, OP_DECSZ, OP_INCSZ, OP_BCLR, OP_BSET, OP_BTSC, OP_BTSS,
        OP_ADDLIT, OP_ANDLIT, OP_ORLIT, OP_LDBANK, OP_LDPAGE, OP_MOVLW, OP_SUBLW, OP_XORLW,
        OP_BRAREL, OP_BRW, OP_CALL, OP_CALL_BY_W, OP_JUMP, OP_RETFI, OP_RETLW, OP_RETSUB,
        OP_CLEAR_WATCHDOG, OP_OPTION, OP_SWRST, OP_STANDBY, OP_PORTDIR, OP_ADDPTR,
        OP_LDIND_INC, OP_STIND_INC, OP_LDIND_IDX, OP_STIND_IDX, OP_ILLEGAL
    } idec_op_t;
endpackage : idec_pkg

// ===== src/idec_decoder.sv
// Local design decisions: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "idec_map.svh"
module idec_decoder
    import idec_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        ce_i,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic [13:0] instr_i,
    input  wire logic        cond_true_i,
    input  wire logic [1:0]  fsr_msb_i,
    output idec_op_t         op_o,
    output logic [5:0]       opcode_o,
    output logic             wr_work_o,
    output logic             wr_file_o,
    output logic [6:0]       file_addr_o,
    output logic [2:0]       bit_pos_o,
    output logic [7:0]       lit8_o,
    output logic [10:0]      lit11_o,
    output logic [8:0]       lit9_o,
    output logic [6:0]       lit7_o,
    output logic [5:0]       lit6_o,
    output logic [4:0]       lit5_o,
    output logic             fsr_sel_o,
    output logic [1:0]       ptr_mode_o,
    output logic [4:0]       flag_mask_o,
    output logic [1:0]       cycles_o,
    output idec_phase_t      phase_o,
    output logic             icyc_start_o
);
    // ****************************************
    // bus registers
    // ****************************************
    logic        src_reg;
    logic [13:0] word_reg;
    logic        wait_reg;
    logic [31:0] rdata_reg;
    logic [13:0] last_reg;
    logic        bus_req;
    logic [13:0] w;

    assign bus_req = avs_read_i | avs_write_i;
    assign w       = src_reg ? word_reg : instr_i;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wait_reg <= 1'b1;
        end else if (ce_i) begin
            wait_reg <= !(bus_req && wait_reg);
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            src_reg  <= `IDEC_CTRL_RST;
            word_reg <= `IDEC_WORD_RST;
        end else if (ce_i && avs_write_i && !wait_reg) begin
            if (avs_address_i == `IDEC_REG_CTRL) begin
                src_reg <= avs_writedata_i[0];
            end
            if (avs_address_i == `IDEC_REG_WORD) begin
                word_reg <= avs_writedata_i[13:0];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (ce_i && avs_read_i && wait_reg) begin
            unique case (avs_address_i)
                `IDEC_REG_CTRL: rdata_reg <= {31'h0000_0000, src_reg};
                `IDEC_REG_WORD: rdata_reg <= {18'h0_0000, word_reg};
                `IDEC_REG_STAT: rdata_reg <= {12'h000, phase_o, cycles_o, 3'h0, flag_mask_o, 2'h0, op_o};
                `IDEC_REG_LAST: rdata_reg <= {18'h0_0000, last_reg};
                default:        rdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    assign avs_readdata_o    = rdata_reg;
    assign avs_waitrequest_o = wait_reg;

    // ****************************************
    // instruction cycle phase
    // ****************************************
    idec_phase_t phase_reg;
    idec_phase_t phase_next;

    always_comb begin
        unique case (phase_reg)
            IDEC_Q1: phase_next = IDEC_Q2;
            IDEC_Q2: phase_next = IDEC_Q3;
            IDEC_Q3: phase_next = IDEC_Q4;
            IDEC_Q4: phase_next = IDEC_Q1;
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phase_reg <= IDEC_Q1;
        end else if (ce_i) begin
            phase_reg <= phase_next;
        end
    end

    // ****************************************
    // combinational decode
    // ****************************************
    idec_op_t    op_next;
    logic [4:0]  fl_next;
    logic [1:0]  base_next;
    logic        cond_op;
    logic        file_op;
    logic        ind_op;
    logic        ind_ptr;

    always_comb begin
        op_next   = OP_ILLEGAL;
        fl_next   = 5'h00;
        base_next = 2'h1;
        cond_op   = 1'b0;
        file_op   = 1'b0;
        ind_op    = 1'b0;
        ind_ptr   = w[`IDEC_PTR_INC_BIT];
        unique case (w[13:12])
            2'b00: begin
                file_op = 1'b1;
                unique case (w[11:8])
                    4'h7: begin op_next = OP_ADD_W_TO_FILE; fl_next = 5'h07; end
                    4'h2: begin op_next = OP_SUB_W_FROM_FILE; fl_next = 5'h07; end
                    4'h5: begin op_next = OP_AND_W_FILE; fl_next = 5'h04; end
                    4'h4: begin op_next = OP_OR_W_FILE; fl_next = 5'h04; end
                    4'h6: begin op_next = OP_XOR_W_FILE; fl_next = 5'h04; end
                    4'hD: begin op_next = OP_RLC;   fl_next = 5'h01; end
                    4'hC: begin op_next = OP_RRC;   fl_next = 5'h01; end
                    4'h9: begin op_next = OP_COMF;  fl_next = 5'h04; end
                    4'h3: begin op_next = OP_DECF;  fl_next = 5'h04; end
                    4'hA: begin op_next = OP_INCF;  fl_next = 5'h04; end
                    4'h8: begin op_next = OP_MOVF;  fl_next = 5'h04; end
                    4'hE: op_next = OP_SWAPF;
                    4'hB: begin op_next = OP_DECSZ; cond_op = 1'b1; end
                    4'hF: begin op_next = OP_INCSZ; cond_op = 1'b1; end
                    4'h1: begin
                        op_next = w[`IDEC_DEST_BIT] ? OP_CLRF : OP_CLRW;
                        fl_next = 5'h04;
                        file_op = w[`IDEC_DEST_BIT];
                    end
                    4'h0: begin
                        file_op = w[`IDEC_DEST_BIT];
                        if (w[7]) begin
                            op_next = OP_MOVWF;
                        end else if (w[6:5] == 2'b01) begin
                            op_next = OP_LDBANK;
                        end else if (w[6:4] == 3'b001) begin
                            op_next = w[3] ? OP_STIND_INC : OP_LDIND_INC;
                            fl_next = w[3] ? 5'h00 : 5'h04;
                            ind_op  = 1'b1;
                        end else begin
                            unique case (w[7:0])
                                8'h00: op_next = OP_NOP;
                                8'h01: op_next = OP_SWRST;
                                8'h08: begin op_next = OP_RETSUB; base_next = 2'h2; end
                                8'h09: begin op_next = OP_RETFI;  base_next = 2'h2; end
                                8'h0A: begin op_next = OP_CALL_BY_W;  base_next = 2'h2; end
                                8'h0B: begin op_next = OP_BRW;    base_next = 2'h2; end
                                8'h62: op_next = OP_OPTION;
                                8'h63: begin op_next = OP_STANDBY; fl_next = 5'h18; end
                                8'h64: begin op_next = OP_CLEAR_WATCHDOG;  fl_next = 5'h18; end
                                8'h60, 8'h61, 8'h65, 8'h66, 8'h67: op_next = OP_PORTDIR;
                                default: op_next = OP_ILLEGAL;
                            endcase
                        end
                    end
                endcase
            end
            2'b01: begin
                file_op = 1'b1;
                unique case (w[11:10])
                    2'b00: op_next = OP_BCLR;
                    2'b01: op_next = OP_BSET;
                    2'b10: begin op_next = OP_BTSC; cond_op = 1'b1; end
                    2'b11: begin op_next = OP_BTSS; cond_op = 1'b1; end
                endcase
            end
            2'b10: begin
                op_next   = w[11] ? OP_JUMP : OP_CALL;
                base_next = 2'h2;
            end
            2'b11: begin
                unique case (w[11:8])
                    4'h0: op_next = OP_MOVLW;
                    4'h1: op_next = w[7] ? OP_LDPAGE : OP_ADDPTR;
                    4'h2, 4'h3: begin op_next = OP_BRAREL; base_next = 2'h2; end
                    4'h4: begin op_next = OP_RETLW; base_next = 2'h2; end
                    4'h5: begin op_next = OP_LSL; fl_next = 5'h05; file_op = 1'b1; end
                    4'h6: begin op_next = OP_LSR; fl_next = 5'h05; file_op = 1'b1; end
                    4'h7: begin op_next = OP_ASR; fl_next = 5'h05; file_op = 1'b1; end
                    4'h8: op_next = OP_ORLIT;
                    4'h9: begin op_next = OP_ANDLIT; fl_next = 5'h04; end
                    4'hA: begin op_next = OP_XORLW; fl_next = 5'h04; end
                    4'hB: begin op_next = OP_SUB_W_FILE_BORROW; fl_next = 5'h07; file_op = 1'b1; end
                    4'hC: begin op_next = OP_SUBLW; fl_next = 5'h07; end
                    4'hD: begin op_next = OP_ADD_W_FILE_CARRY; fl_next = 5'h07; file_op = 1'b1; end
                    4'hE: begin op_next = OP_ADDLIT; fl_next = 5'h07; end
                    4'hF: begin
                        op_next = w[7] ? OP_STIND_IDX : OP_LDIND_IDX;
                        fl_next = w[7] ? 5'h00 : 5'h04;
                        ind_op  = 1'b1;
                        ind_ptr = w[`IDEC_PTR_OFS_BIT];
                    end
                endcase
            end
        endcase
    end

    // ****************************************
    // cycle count
    // ****************************************
    logic       ind_hit;
    logic [1:0] cyc_next;

    always_comb begin
        ind_hit = 1'b0;
        if (ind_op) begin
            ind_hit = fsr_msb_i[ind_ptr];
        end else if (file_op && (w[6:0] == `IDEC_INDF0_ADDR || w[6:0] == `IDEC_INDF1_ADDR)) begin
            ind_hit = fsr_msb_i[w[0]];
        end
        cyc_next = base_next;
        if (cond_op && cond_true_i) begin
            cyc_next = 2'h2;
        end
        cyc_next = cyc_next + {1'b0, ind_hit};
    end

    // ****************************************
    // output registers
    // ****************************************
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            op_o        <= OP_NOP;
            flag_mask_o <= 5'h00;
            cycles_o    <= 2'h1;
            last_reg    <= `IDEC_WORD_RST;
        end else if (ce_i) begin
            op_o        <= op_next;
            flag_mask_o <= fl_next;
            cycles_o    <= cyc_next;
            last_reg    <= w;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            opcode_o    <= 6'h00;
            wr_work_o   <= 1'b0;
            wr_file_o   <= 1'b0;
            file_addr_o <= 7'h00;
            bit_pos_o   <= 3'h0;
            lit8_o      <= 8'h00;
            lit11_o     <= 11'h000;
            lit9_o      <= 9'h000;
            lit7_o      <= 7'h00;
            lit6_o      <= 6'h00;
            lit5_o      <= 5'h00;
            fsr_sel_o   <= 1'b0;
            ptr_mode_o  <= 2'h0;
        end else if (ce_i) begin
            opcode_o    <= w[`IDEC_OP6_HI:`IDEC_OP6_LO];
            wr_work_o   <= file_op && !w[`IDEC_DEST_BIT] && w[13:12] != 2'b01;
            wr_file_o   <= file_op && w[`IDEC_DEST_BIT] && w[13:12] != 2'b01;
            file_addr_o <= w[6:0];
            bit_pos_o   <= w[`IDEC_BITN_HI:`IDEC_BITN_LO];
            lit8_o      <= w[7:0];
            lit11_o     <= w[10:0];
            lit9_o      <= w[8:0];
            lit7_o      <= w[6:0];
            lit6_o      <= w[5:0];
            lit5_o      <= w[4:0];
            fsr_sel_o   <= ind_op ? ind_ptr : w[`IDEC_PTR_OFS_BIT];
            ptr_mode_o  <= w[1:0];
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phase_o      <= IDEC_Q1;
            icyc_start_o <= 1'b0;
        end else if (ce_i) begin
            phase_o      <= phase_next;
            icyc_start_o <= (phase_next == IDEC_Q1);
        end
    end
endmodule : idec_decoder
`default_nettype wire

// ===== tb/idec_decoder_chk.sv
`timescale 1ns/10ps
`default_nettype none
module idec_decoder_chk
    import idec_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rstn_i,
    input wire logic        ce_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic        avs_waitrequest_o,
    input var  idec_op_t    op_o,
    input wire logic [5:0]  opcode_o,
    input wire logic        wr_work_o,
    input wire logic        wr_file_o,
    input wire logic [7:0]  lit8_o,
    input wire logic [4:0]  flag_mask_o,
    input wire logic [1:0]  cycles_o,
    input var  idec_phase_t phase_o,
    input wire logic        icyc_start_o
);
    // ****************************************
    // decoder and bus properties
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    function automatic idec_phase_t nxt(input idec_phase_t p);
        case (p)
            IDEC_Q1: nxt = IDEC_Q2;
            IDEC_Q2: nxt = IDEC_Q3;
            IDEC_Q3: nxt = IDEC_Q4;
            default: nxt = IDEC_Q1;
        endcase
    endfunction : nxt
    a_phase_step: assert property (ce_i |=> phase_o == nxt($past(phase_o)))
        else $error("phase did not step");
    a_start_pulse: assert property (ce_i && phase_o == IDEC_Q4 |=> icyc_start_o && phase_o == IDEC_Q1)
        else $error("cycle start missing");
    a_start_place: assert property (icyc_start_o |-> phase_o == IDEC_Q1)
        else $error("cycle start off phase");
    a_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i |=> !avs_waitrequest_o)
        else $error("bus answer late");
    a_bus_single: assert property (!avs_waitrequest_o && ce_i |=> avs_waitrequest_o)
        else $error("bus answer too long");
    a_dest_sel: assert property (op_o == OP_ADD_W_TO_FILE |-> opcode_o == 6'h07 && wr_file_o == lit8_o[7] && wr_work_o == !lit8_o[7])
        else $error("destination wrong");
    a_branch_two: assert property (op_o inside {OP_CALL, OP_JUMP, OP_BRAREL, OP_BRW, OP_CALL_BY_W, OP_RETSUB, OP_RETFI}
        |-> cycles_o == 2'h2)
        else $error("branch not two cycles");
    a_literal_one: assert property (op_o inside {OP_ADDLIT, OP_ANDLIT, OP_ORLIT} |-> cycles_o == 2'h1)
        else $error("literal op not one cycle");
    a_skip_flags: assert property (op_o inside {OP_DECSZ, OP_INCSZ, OP_BCLR, OP_BSET, OP_BTSC, OP_BTSS}
        |-> flag_mask_o == 5'h00)
        else $error("skip form touches flags");
    a_wdt_flags: assert property (op_o inside {OP_CLEAR_WATCHDOG, OP_STANDBY} |-> flag_mask_o == 5'h18)
        else $error("watchdog flags wrong");
endmodule : idec_decoder_chk
bind idec_decoder idec_decoder_chk idec_decoder_chk_i (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o), .op_o(op_o),
    .opcode_o(opcode_o), .wr_work_o(wr_work_o), .wr_file_o(wr_file_o), .lit8_o(lit8_o),
    .flag_mask_o(flag_mask_o), .cycles_o(cycles_o), .phase_o(phase_o), .icyc_start_o(icyc_start_o));
`default_nettype wire

// ===== tb/idec_fetch_model.sv
`timescale 1ns/10ps
`default_nettype none
module idec_fetch_model (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic [13:0] word_i,
    input  wire logic        cond_i,
    input  wire logic [1:0]  msb_i,
    output logic [13:0]      instr_o,
    output logic             cond_true_o,
    output logic [1:0]       fsr_msb_o
);
    // ****************************************
    // fetch register and datapath status
    // ****************************************
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {instr_o, cond_true_o, fsr_msb_o} <= '0;
        end else begin
            {instr_o, cond_true_o, fsr_msb_o} <= {word_i, cond_i, msb_i};
        end
    end
endmodule : idec_fetch_model
`default_nettype wire

// ===== tb/idec_decoder_bench.sv
`timescale 1ns/10ps
`default_nettype none
module idec_decoder_bench;
    import idec_pkg::*;
    logic clk_i, rstn_i, ce_i, avs_read_i, avs_write_i, avs_waitrequest_o, cond_true_i, cond_r;
    logic wr_work_o, wr_file_o, fsr_sel_o, icyc_start_o;
    logic [3:0] avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, q;
    logic [13:0] instr_i, word_r;
    logic [1:0] fsr_msb_i, msb_r, ptr_mode_o, cycles_o;
    logic [5:0] opcode_o, lit6_o;
    logic [6:0] file_addr_o, lit7_o;
    logic [2:0] bit_pos_o;
    logic [7:0] lit8_o;
    logic [10:0] lit11_o;
    logic [8:0] lit9_o;
    logic [4:0] lit5_o, flag_mask_o;
    idec_op_t op_o;
    idec_phase_t phase_o, p;
    int errors, n_checks;
    idec_decoder idec_decoder_i (.clk_i, .rstn_i, .ce_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .instr_i, .cond_true_i, .fsr_msb_i, .op_o,
        .opcode_o, .wr_work_o, .wr_file_o, .file_addr_o, .bit_pos_o, .lit8_o, .lit11_o, .lit9_o, .lit7_o,
        .lit6_o, .lit5_o, .fsr_sel_o, .ptr_mode_o, .flag_mask_o, .cycles_o, .phase_o, .icyc_start_o);
    idec_fetch_model idec_fetch_model_i (.clk_i(clk_i), .rstn_i(rstn_i), .word_i(word_r), .cond_i(cond_r),
        .msb_i(msb_r), .instr_o(instr_i), .cond_true_o(cond_true_i), .fsr_msb_o(fsr_msb_i));
    // ****************************************
    // tasks
    // ****************************************
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask : cmp
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_read_i <= !w;
        avs_write_i <= w;
        avs_writedata_i <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (avs_waitrequest_o !== 1'b0 && k < 100);
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        if (k >= 100) cmp(32'h0, 32'h1);
    endtask : bus
    task automatic t(input logic [13:0] w, input logic c, input logic [1:0] m, input idec_op_t o,
                     input logic [4:0] f, input logic [1:0] n, input logic b);
        logic ptr;
        ptr = (o == OP_LDIND_INC || o == OP_STIND_INC) ? w[2] : w[6];
        @(posedge clk_i);
        word_r <= w;
        cond_r <= c;
        msb_r <= m;
        repeat (2) @(posedge clk_i);
        #1;
        cmp({op_o, flag_mask_o, cycles_o, wr_work_o, wr_file_o}, {o, f, n, b & ~w[7], b & w[7]});
        cmp({opcode_o, file_addr_o, bit_pos_o, lit8_o}, {w[13:8], w[6:0], w[9:7], w[7:0]});
        cmp({lit11_o, lit9_o, lit7_o}, {w[10:0], w[8:0], w[6:0]});
        cmp({lit6_o, lit5_o, fsr_sel_o, ptr_mode_o}, {w[5:0], w[4:0], ptr, w[1:0]});
    endtask : t
    // ****************************************
    // tests
    // ****************************************
    initial begin
        #100us;
        errors++;
        print_verdict();
    end
    initial begin
        {rstn_i, avs_read_i, avs_write_i, cond_r} = '0;
        {avs_address_i, avs_writedata_i, word_r, msb_r} = '0;
        ce_i = 1'b1;
        repeat (6) @(posedge clk_i);
        #1;
        cmp({op_o, cycles_o, phase_o, avs_waitrequest_o, avs_readdata_o}, {OP_NOP, 2'h1, IDEC_Q1, 1'b1, 32'h0});
        @(posedge clk_i);
        rstn_i <= 1'b1;
        t(14'h07D5, 0, 2'h0, OP_ADD_W_TO_FILE, 5'h07, 2'h1, 1);
        t(14'h0255, 0, 2'h0, OP_SUB_W_FROM_FILE, 5'h07, 2'h1, 1);
        t(14'h3DAA, 0, 2'h0, OP_ADD_W_FILE_CARRY, 5'h07, 2'h1, 1);
        t(14'h3B12, 0, 2'h0, OP_SUB_W_FILE_BORROW, 5'h07, 2'h1, 1);
        t(14'h3700, 0, 2'h0, OP_ASR, 5'h05, 2'h1, 1);
        t(14'h3580, 0, 2'h0, OP_LSL, 5'h05, 2'h1, 1);
        t(14'h3601, 0, 2'h0, OP_LSR, 5'h05, 2'h1, 1);
        t(14'h0D00, 0, 2'h0, OP_RLC, 5'h01, 2'h1, 1);
        t(14'h0C80, 0, 2'h0, OP_RRC, 5'h01, 2'h1, 1);
        t(14'h0500, 0, 2'h0, OP_AND_W_FILE, 5'h04, 2'h1, 1);
        t(14'h0480, 0, 2'h0, OP_OR_W_FILE, 5'h04, 2'h1, 1);
        t(14'h0633, 0, 2'h0, OP_XOR_W_FILE, 5'h04, 2'h1, 1);
        t(14'h0B00, 0, 2'h0, OP_DECSZ, 5'h00, 2'h1, 1);
        t(14'h0F80, 1, 2'h0, OP_INCSZ, 5'h00, 2'h2, 1);
        t(14'h0B00, 1, 2'h1, OP_DECSZ, 5'h00, 2'h3, 1);
        t(14'h0781, 0, 2'h1, OP_ADD_W_TO_FILE, 5'h07, 2'h1, 1);
        t(14'h1000, 0, 2'h0, OP_BCLR, 5'h00, 2'h1, 0);
        t(14'h17FF, 0, 2'h0, OP_BSET, 5'h00, 2'h1, 0);
        t(14'h1A80, 0, 2'h0, OP_BTSC, 5'h00, 2'h1, 0);
        t(14'h1D00, 1, 2'h0, OP_BTSS, 5'h00, 2'h2, 0);
        t(14'h3EC3, 0, 2'h0, OP_ADDLIT, 5'h07, 2'h1, 0);
        t(14'h3955, 0, 2'h0, OP_ANDLIT, 5'h04, 2'h1, 0);
        t(14'h38F0, 0, 2'h0, OP_ORLIT, 5'h00, 2'h1, 0);
        t(14'h0008, 0, 2'h0, OP_RETSUB, 5'h00, 2'h2, 0);
        t(14'h0009, 0, 2'h0, OP_RETFI, 5'h00, 2'h2, 0);
        t(14'h000A, 0, 2'h0, OP_CALL_BY_W, 5'h00, 2'h2, 0);
        t(14'h000B, 0, 2'h0, OP_BRW, 5'h00, 2'h2, 0);
        t(14'h2555, 0, 2'h0, OP_CALL, 5'h00, 2'h2, 0);
        t(14'h2ABC, 0, 2'h0, OP_JUMP, 5'h00, 2'h2, 0);
        t(14'h33FF, 0, 2'h0, OP_BRAREL, 5'h00, 2'h2, 0);
        t(14'h31C5, 0, 2'h0, OP_LDPAGE, 5'h00, 2'h1, 0);
        t(14'h003A, 0, 2'h0, OP_LDBANK, 5'h00, 2'h1, 0);
        t(14'h3165, 0, 2'h0, OP_ADDPTR, 5'h00, 2'h1, 0);
        t(14'h0013, 0, 2'h0, OP_LDIND_INC, 5'h04, 2'h1, 0);
        t(14'h001E, 0, 2'h2, OP_STIND_INC, 5'h00, 2'h2, 0);
        t(14'h3F25, 0, 2'h0, OP_LDIND_IDX, 5'h04, 2'h1, 0);
        t(14'h3FC0, 0, 2'h2, OP_STIND_IDX, 5'h00, 2'h2, 0);
        t(14'h0064, 0, 2'h0, OP_CLEAR_WATCHDOG, 5'h18, 2'h1, 0);
        t(14'h0063, 0, 2'h0, OP_STANDBY, 5'h18, 2'h1, 0);
        t(14'h0062, 0, 2'h0, OP_OPTION, 5'h00, 2'h1, 0);
        t(14'h0065, 0, 2'h0, OP_PORTDIR, 5'h00, 2'h1, 0);
        t(14'h0001, 0, 2'h0, OP_SWRST, 5'h00, 2'h1, 0);
        t(14'h0000, 0, 2'h0, OP_NOP, 5'h00, 2'h1, 0);
        t(14'h3EC3, 0, 2'h0, OP_ADDLIT, 5'h07, 2'h1, 0);
        bus(0, 4'h2, 32'h0);
        cmp({q[17:16], q[12:8], q[5:0]}, {2'h1, 5'h07, OP_ADDLIT});
        bus(0, 4'h0, 32'h0);
        cmp(q, 32'h0);
        bus(1, 4'hC, 32'hFFFF_FFFF);
        bus(0, 4'hC, 32'h0);
        cmp(q, 32'h0);
        bus(1, 4'h1, 32'h0000_3F80);
        bus(1, 4'h0, 32'h0000_0001);
        repeat (3) @(posedge clk_i);
        #1;
        cmp({op_o, flag_mask_o}, {OP_STIND_IDX, 5'h00});
        bus(0, 4'h1, 32'h0);
        cmp(q, 32'h0000_3F80);
        bus(0, 4'h3, 32'h0);
        cmp(q, 32'h0000_3F80);
        bus(1, 4'h0, 32'h0);
        @(posedge clk_i);
        ce_i <= 1'b0;
        word_r <= 14'h0700;
        @(posedge clk_i);
        #1;
        p = phase_o;
        repeat (5) @(posedge clk_i);
        #1;
        cmp({phase_o, op_o}, {p, OP_ADDLIT});
        @(posedge clk_i);
        ce_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        print_verdict();
    end
endmodule : idec_decoder_bench
`default_nettype wire
